// ### rtl/dsc_pkg.sv
// Package for the debug status and comparator control block.
// Assumes a single 50 MHz clock domain and a plain register port.
package dsc_pkg;
	// Register offsets (byte addresses on the plain port)
	localparam logic [7:0] OFS_STATUS  = 8'h00;
	localparam logic [7:0] OFS_CMP_CTL = 8'h01;
	localparam logic [7:0] OFS_CTRL1   = 8'h02;
	// Status field positions
	localparam int BIT_TRACE_FULL = 7;
	localparam int BIT_PROF_ACT   = 4;
	// Comparator control field positions
	localparam int BIT_DATA_MISM  = 6;
	localparam int BIT_PC_SEL     = 5;
	localparam int BIT_DIR_VAL    = 3;
	localparam int BIT_DIR_EN     = 2;
	localparam int BIT_CMP_ON     = 0;
	// Control one field: session arm bit
	localparam int BIT_ARM        = 7;
	// Writable mask and reset values
	localparam logic [7:0] CMP_CTL_MASK  = 8'h6D;
	localparam logic [7:0] CMP_CTL_RESET = 8'h00;
	localparam logic [7:0] CTRL1_RESET   = 8'h00;
	// Sequencer states
	typedef enum logic [2:0] {
		SEQ_DISARMED = 3'b000,
		SEQ_FIRST    = 3'b001,
		SEQ_SECOND   = 3'b010,
		SEQ_THIRD    = 3'b011,
		SEQ_FINAL    = 3'b100
	} dsc_seq_type;
endpackage : dsc_pkg

// ### rtl/dsc_comparator.sv
// Comparator match logic for one address/data comparator.
// Assumes address and data equality inputs are computed by the caller.
`timescale 1ns/1ps
module dsc_comparator
	import dsc_pkg::*;
(
	input  wire logic [7:0] ctl_in,
	input  wire logic       pc_hit_in,
	input  wire logic       addr_hit_in,
	input  wire logic       data_eq_in,
	input  wire logic       dir_in,
	output logic            match_out
);
	// Match terms of the selected mode
	wire logic data_ok;
	wire logic dir_ok;
	wire logic data_match;
	assign data_ok    = ctl_in[BIT_DATA_MISM] ? ~data_eq_in : data_eq_in;
	assign dir_ok     = ~ctl_in[BIT_DIR_EN] | (dir_in == ctl_in[BIT_DIR_VAL]);
	assign data_match = addr_hit_in & data_ok & dir_ok;
	assign match_out  = ctl_in[BIT_CMP_ON] &
		(ctl_in[BIT_PC_SEL] ? pc_hit_in : data_match);
endmodule : dsc_comparator

// ### rtl/dsc_status.sv
// Trace-full and profiling-active status flags.
// Assumes event pulses are one cycle long and synchronous.
`timescale 1ns/1ps
module dsc_status (
	input  wire logic clock_in,
	input  wire logic por_n_in,
	input  wire logic arm_write_in,
	input  wire logic buffer_filled_in,
	input  wire logic prof_entry_in,
	input  wire logic prof_end_in,
	output logic      trace_full_out,
	output logic      prof_active_out
);
	logic trace_full_ff;
	logic prof_act_ff;
	// Trace-full cleared on arm write or por_n_in, kept over resetn_in
	always_ff @(posedge clock_in) begin
		if (!por_n_in) begin
			trace_full_ff <= 1'b0;
		end else if (buffer_filled_in) begin
			trace_full_ff <= 1'b1;
		end else if (arm_write_in) begin
			trace_full_ff <= 1'b0;
		end
	end
	// Profiling active from first entry to transmission end
	always_ff @(posedge clock_in) begin
		if (!por_n_in) begin
			prof_act_ff <= 1'b0;
		end else if (prof_entry_in) begin
			prof_act_ff <= 1'b1;
		end else if (prof_end_in) begin
			prof_act_ff <= 1'b0;
		end
	end
	assign trace_full_out  = trace_full_ff;
	assign prof_active_out = prof_act_ff;

	// Flag set, clear and hold checks
	chk_arm_clears_full: assert property (
		@(posedge clock_in) disable iff (!por_n_in)
		arm_write_in && !buffer_filled_in |=> !trace_full_out)
		else $error("trace full not cleared by arm");
	chk_fill_sets_full: assert property (
		@(posedge clock_in) disable iff (!por_n_in)
		buffer_filled_in |=> trace_full_out)
		else $error("trace full not set");
	chk_full_holds: assert property (
		@(posedge clock_in) disable iff (!por_n_in)
		trace_full_out && !arm_write_in |=> trace_full_out)
		else $error("trace full dropped without arm");
	chk_prof_set: assert property (
		@(posedge clock_in) disable iff (!por_n_in)
		prof_entry_in |=> prof_active_out)
		else $error("profiling active not set");
	chk_prof_clear: assert property (
		@(posedge clock_in) disable iff (!por_n_in)
		prof_end_in && !prof_entry_in |=> !prof_active_out)
		else $error("profiling active not cleared");
endmodule : dsc_status

// ### rtl/dsc_top.sv
// Debug status register and comparator A control with trigger sequencer.
// Assumes core bus signals are synchronous to clock_in; plain register port.
`timescale 1ns/1ps
module dsc_top
	import dsc_pkg::*;
#(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 32
) (
	input  wire logic              clock_in,
	input  wire logic              resetn_in,
	input  wire logic              por_n_in,
	input  wire logic [7:0]        reg_addr_in,
	input  wire logic [7:0]        reg_wdata_in,
	input  wire logic              reg_write_in,
	input  wire logic              reg_read_in,
	output logic      [7:0]        reg_rdata_out,
	input  wire logic [ADDR_W-1:0] cmp_addr_in,
	input  wire logic [ADDR_W-1:0] cmp_pc_in,
	input  wire logic [DATA_W-1:0] cmp_data_in,
	input  wire logic [DATA_W-1:0] cmp_mask_in,
	input  wire logic [ADDR_W-1:0] bus_addr_in,
	input  wire logic [DATA_W-1:0] bus_data_in,
	input  wire logic              bus_read_in,
	input  wire logic              bus_valid_in,
	input  wire logic [ADDR_W-1:0] pc_in,
	input  wire logic              pc_valid_in,
	input  wire logic [1:0]        next_on_match_in,
	input  wire logic              internal_end_in,
	input  wire logic              buffer_filled_in,
	input  wire logic              prof_entry_in,
	input  wire logic              prof_end_in,
	output logic                   match_out,
	output logic                   armed_out,
	output logic                   trace_full_out,
	output logic [2:0]             sequencer_state_out
);
	logic [7:0]  cmp_ctl_ff;
	logic        arm_ff;
	logic [7:0]  rdata_ff;
	dsc_seq_type seq_ff;
	dsc_seq_type nxt_seq;
	logic [2:0]  state_field_ff;
	logic [2:0]  nxt_state_field;
	wire logic   prof_active;
	wire logic   trace_full;

	// Assertions sample on the system clock, idle in reset
	default clocking cb_sys @(posedge clock_in); endclocking
	default disable iff (!resetn_in);

	// Decoded register strobes
	wire logic wr_ctl;
	wire logic wr_ctrl1;
	wire logic arm_write;
	wire logic disarm_write;
	assign wr_ctl       = reg_write_in && reg_addr_in == OFS_CMP_CTL
		&& !arm_ff && !prof_active;
	assign wr_ctrl1     = reg_write_in && reg_addr_in == OFS_CTRL1;
	assign arm_write    = wr_ctrl1 && reg_wdata_in[BIT_ARM];
	assign disarm_write = wr_ctrl1 && !reg_wdata_in[BIT_ARM];

	// Comparator equality terms
	wire logic addr_hit;
	wire logic pc_hit;
	wire logic data_eq;
	wire logic cmp_match;
	assign addr_hit = bus_valid_in && bus_addr_in == cmp_addr_in;
	assign pc_hit   = pc_valid_in && pc_in == cmp_pc_in;
	assign data_eq  = ((bus_data_in ^ cmp_data_in) & cmp_mask_in) == '0;

	dsc_comparator u_cmp (
		.ctl_in      (cmp_ctl_ff),
		.pc_hit_in   (pc_hit),
		.addr_hit_in (addr_hit),
		.data_eq_in  (data_eq),
		.dir_in      (bus_read_in),
		.match_out   (cmp_match)
	);

	dsc_status u_status (
		.clock_in         (clock_in),
		.por_n_in         (por_n_in),
		.arm_write_in     (arm_write),
		.buffer_filled_in (buffer_filled_in),
		.prof_entry_in    (prof_entry_in),
		.prof_end_in      (prof_end_in),
		.trace_full_out   (trace_full),
		.prof_active_out  (prof_active)
	);

	// Comparator control register, guarded writes
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			cmp_ctl_ff <= CMP_CTL_RESET;
		end else if (wr_ctl) begin
			cmp_ctl_ff <= reg_wdata_in & CMP_CTL_MASK;
		end
	end

	// Session arm bit
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			arm_ff <= 1'b0;
		end else if (wr_ctrl1) begin
			arm_ff <= reg_wdata_in[BIT_ARM];
		end else if (internal_end_in || seq_ff == SEQ_FINAL) begin
			arm_ff <= 1'b0;
		end
	end

	// Next sequencer state on match while armed
	function automatic dsc_seq_type seq_target(input logic [1:0] sel,
			input dsc_seq_type cur);
		unique case (sel)
			2'b01:   seq_target = SEQ_SECOND;
			2'b10:   seq_target = SEQ_THIRD;
			2'b11:   seq_target = SEQ_FINAL;
			default: seq_target = cur;
		endcase
	endfunction : seq_target

	// Sequencer next state and state field
	always_comb begin
		nxt_seq         = seq_ff;
		nxt_state_field = state_field_ff;
		if (arm_write) begin
			nxt_seq         = SEQ_FIRST;
			nxt_state_field = SEQ_FIRST;
		end else if (disarm_write) begin
			nxt_seq         = SEQ_DISARMED;
		end else if (arm_ff && (internal_end_in || seq_ff == SEQ_FINAL)) begin
			nxt_seq         = SEQ_DISARMED;
			nxt_state_field = SEQ_DISARMED;
		end else if (arm_ff && cmp_match) begin
			nxt_seq         = seq_target(next_on_match_in, seq_ff);
			nxt_state_field = nxt_seq;
		end
	end

	// Sequencer registers, only legal codes stored
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			seq_ff         <= SEQ_DISARMED;
			state_field_ff <= SEQ_DISARMED;
		end else begin
			seq_ff         <= nxt_seq;
			state_field_ff <= nxt_state_field;
		end
	end

	// Read data mux and register
	wire logic [7:0] status_word;
	wire logic [7:0] rd_mux;
	assign status_word = {trace_full, 2'b00, prof_active, 1'b0, state_field_ff};
	assign rd_mux = (reg_addr_in == OFS_STATUS)  ? status_word :
		(reg_addr_in == OFS_CMP_CTL) ? cmp_ctl_ff :
		(reg_addr_in == OFS_CTRL1)   ? {arm_ff, 7'b000_0000} : 8'h00;
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= reg_read_in ? rd_mux : 8'h00;
		end
	end

	assign reg_rdata_out       = rdata_ff;
	assign match_out           = cmp_match;
	assign armed_out           = arm_ff;
	assign trace_full_out      = trace_full;
	assign sequencer_state_out = state_field_ff;

	// Session steps used by the multi-cycle checks
	sequence s_arm_cmd;
		wr_ctrl1 && reg_wdata_in[BIT_ARM];
	endsequence
	sequence s_session_open;
		arm_ff && state_field_ff == 3'b001;
	endsequence
	sequence s_final_entry;
		arm_ff && !wr_ctrl1 && !internal_end_in && seq_ff != SEQ_FINAL
		&& cmp_match && next_on_match_in == 2'b11;
	endsequence
	sequence s_final_exit;
		state_field_ff == 3'b100 ##1 (!arm_ff && state_field_ff == 3'b000);
	endsequence

	// Control register locked while armed
	chk_ctl_write_lock: assert property (
		reg_write_in && reg_addr_in == OFS_CMP_CTL && arm_ff
		|=> $stable(cmp_ctl_ff))
		else $error("control written while armed");

	// Control register locked while profiling
	chk_ctl_lock_prof: assert property (
		reg_write_in && reg_addr_in == OFS_CMP_CTL && prof_active
		|=> $stable(cmp_ctl_ff))
		else $error("control written while profiling");

	// Accepted control write lands masked
	chk_ctl_write_lands: assert property (
		wr_ctl
		|=> cmp_ctl_ff == ($past(reg_wdata_in) & CMP_CTL_MASK))
		else $error("control write lost");

	// Unused control bits stay zero
	chk_ctl_spare_zero: assert property (
		(cmp_ctl_ff & ~CMP_CTL_MASK) == 8'h00)
		else $error("unused control bit set");

	// Control readable at any time
	chk_ctl_read: assert property (
		reg_read_in && reg_addr_in == OFS_CMP_CTL
		|=> reg_rdata_out == $past(cmp_ctl_ff))
		else $error("control read wrong");

	// Status read shows flags and state field
	chk_status_read: assert property (
		reg_read_in && reg_addr_in == OFS_STATUS
		|=> reg_rdata_out == {$past(trace_full), 2'b00, $past(prof_active), 1'b0,
			$past(state_field_ff)})
		else $error("status read wrong");

	// Arming forces state one
	chk_arm_state_one: assert property (
		arm_write
		|=> state_field_ff == 3'b001)
		else $error("arming did not force state one");

	// Arm command opens a session in state one
	chk_arm_opens_session: assert property (
		s_arm_cmd
		|=> s_session_open)
		else $error("arm did not open session");

	// Software disarm keeps the field
	chk_disarm_holds: assert property (
		disarm_write
		|=> $stable(state_field_ff))
		else $error("disarm changed state field");

	// Software disarm drops the sequencer
	chk_disarm_drops_arm: assert property (
		disarm_write
		|=> !arm_ff && seq_ff == SEQ_DISARMED)
		else $error("disarm left session open");

	// Disarmed field only moves on a control one write
	chk_idle_field_hold: assert property (
		!arm_ff && !wr_ctrl1
		|=> $stable(state_field_ff))
		else $error("field moved while disarmed");

	// Internal end clears field and arm
	chk_internal_end: assert property (
		arm_ff && internal_end_in && !wr_ctrl1
		|=> state_field_ff == 3'b000 && !arm_ff)
		else $error("internal end did not clear state");

	// Final state ends the session one cycle later
	chk_final_ends_session: assert property (
		s_final_entry ##1 !wr_ctrl1
		|-> s_final_exit)
		else $error("final state did not end session");

	// Match moves the field to the selected state
	chk_match_advance: assert property (
		arm_ff && !wr_ctrl1 && !internal_end_in && seq_ff != SEQ_FINAL
		&& cmp_match && next_on_match_in != 2'b00
		|=> state_field_ff == {1'b0, $past(next_on_match_in)} + 3'b001)
		else $error("match did not move state");

	// No effective match keeps the field
	chk_no_match_hold: assert property (
		arm_ff && !wr_ctrl1 && !internal_end_in && seq_ff != SEQ_FINAL
		&& !(cmp_match && next_on_match_in != 2'b00)
		|=> $stable(state_field_ff))
		else $error("state moved without match");

	// Field equals the sequencer state in a session
	chk_field_matches_seq: assert property (
		arm_ff
		|-> state_field_ff == seq_ff)
		else $error("field differs from sequencer");

	// Field change mirrors the sequencer
	chk_state_follows: assert property (
		arm_ff && !wr_ctrl1 && !internal_end_in && seq_ff != SEQ_FINAL
		&& $changed(seq_ff) |-> state_field_ff == seq_ff)
		else $error("state field lags sequencer");

	// Disabled comparator cannot move the sequencer
	chk_off_holds_seq: assert property (
		!cmp_ctl_ff[BIT_CMP_ON] && arm_ff && !wr_ctrl1 && !internal_end_in
		&& seq_ff != SEQ_FINAL |=> $stable(seq_ff))
		else $error("sequencer moved with comparator off");

	// Sequencer holds only legal codes
	chk_seq_legal: assert property (
		seq_ff inside {SEQ_DISARMED, SEQ_FIRST, SEQ_SECOND, SEQ_THIRD, SEQ_FINAL})
		else $error("sequencer in illegal code");

	// Field never shows a reserved code
	chk_no_reserved: assert property (
		state_field_ff <= 3'b100)
		else $error("reserved state code");

	// Disabled comparator never matches
	chk_cmp_off_quiet: assert property (
		!cmp_ctl_ff[BIT_CMP_ON]
		|-> !match_out)
		else $error("match while comparator off");

	// Wrong direction blocks the match
	chk_dir_no_match: assert property (
		!cmp_ctl_ff[BIT_PC_SEL] && cmp_ctl_ff[BIT_DIR_EN]
		&& bus_read_in != cmp_ctl_ff[BIT_DIR_VAL] |-> !match_out)
		else $error("match with wrong direction");

	// Right direction leaves the data term in charge
	chk_dir_match_ok: assert property (
		!cmp_ctl_ff[BIT_PC_SEL] && cmp_ctl_ff[BIT_CMP_ON] && addr_hit
		&& cmp_ctl_ff[BIT_DIR_EN] && bus_read_in == cmp_ctl_ff[BIT_DIR_VAL]
		|-> match_out == (data_eq ^ cmp_ctl_ff[BIT_DATA_MISM]))
		else $error("right direction lost match");

	// Data mode follows equality or difference
	chk_data_mode_match: assert property (
		!cmp_ctl_ff[BIT_PC_SEL] && cmp_ctl_ff[BIT_CMP_ON] && addr_hit
		&& !cmp_ctl_ff[BIT_DIR_EN]
		|-> match_out == (data_eq ^ cmp_ctl_ff[BIT_DATA_MISM]))
		else $error("data compare wrong");

	// PC mode ignores data and direction
	chk_pc_mode_match: assert property (
		cmp_ctl_ff[BIT_PC_SEL]
		|-> match_out == (cmp_ctl_ff[BIT_CMP_ON] && pc_hit))
		else $error("pc compare wrong");

	// Data mode needs an address hit
	chk_no_addr_quiet: assert property (
		!cmp_ctl_ff[BIT_PC_SEL] && !addr_hit
		|-> !match_out)
		else $error("match without address hit");
endmodule : dsc_top

// ### bench/dsc_core_model.sv
// Core bus partner: data accesses and executed PC per request kind.
// Assumes kind bits change right after a rising clock edge.
`timescale 1ns/1ps
module dsc_core_model (
	input  wire logic        clock_in,
	input  wire logic [4:0]  kind_in,
	input  wire logic [23:0] cmp_addr_in,
	input  wire logic [23:0] cmp_pc_in,
	input  wire logic [31:0] cmp_data_in,
	input  wire logic [31:0] cmp_mask_in,
	output logic      [23:0] bus_addr_out,
	output logic      [31:0] bus_data_out,
	output logic             bus_read_out,
	output logic             bus_valid_out,
	output logic      [23:0] pc_out,
	output logic             pc_valid_out
);
	logic [31:0] noise_ff = 32'h5a5a_a5a5;
	// Idle bus shows a pattern that changes every cycle
	always_ff @(posedge clock_in) noise_ff <= ~noise_ff + 32'h0000_0001;
	// Hit drives the compared value; a data miss flips one compared bit, an address or PC miss flips all bits
	assign bus_valid_out = kind_in[0];
	assign bus_read_out  = kind_in[0] ? kind_in[1] : noise_ff[0];
	assign bus_addr_out  = !kind_in[0] ? noise_ff[23:0] : kind_in[2] ? cmp_addr_in : ~cmp_addr_in;
	assign bus_data_out  = !kind_in[0] ? noise_ff : kind_in[3] ? cmp_data_in
		: cmp_data_in ^ (cmp_mask_in & -cmp_mask_in);
	assign pc_valid_out  = 1'b1;
	assign pc_out        = kind_in[4] ? cmp_pc_in : ~cmp_pc_in;
endmodule : dsc_core_model

// ### bench/dsc_top_tb.sv
// Self-checking bench for the debug status and comparator control.
// Assumes the package, the design and the core bus partner compiled first.
`timescale 1ns/1ps
module dsc_top_tb
	import dsc_pkg::*;
;
	logic        clock_in, resetn_in, por_n_in, wr_s, rd_s, match, armed, full;
	logic [7:0]  addr, wdata, rdata;
	logic [4:0]  kind;
	logic [3:0]  ev;
	logic [1:0]  nom;
	logic [2:0]  st;
	logic [23:0] c_addr, c_pc, b_addr, pc;
	logic [31:0] c_data, c_mask, b_data;
	logic        b_read, b_valid, pc_valid;
	int          error_cnt, n_compared, i, m_ctl, m_st, m_full, m_prof, m_arm;
	int          seed = 32'h06ce_bcb7;

	dsc_top DUT (.clock_in(clock_in), .resetn_in(resetn_in), .por_n_in(por_n_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s),
		.reg_rdata_out(rdata), .cmp_addr_in(c_addr), .cmp_pc_in(c_pc), .cmp_data_in(c_data),
		.cmp_mask_in(c_mask), .bus_addr_in(b_addr), .bus_data_in(b_data), .bus_read_in(b_read),
		.bus_valid_in(b_valid), .pc_in(pc), .pc_valid_in(pc_valid), .next_on_match_in(nom),
		.internal_end_in(ev[3]), .buffer_filled_in(ev[0]), .prof_entry_in(ev[1]),
		.prof_end_in(ev[2]), .match_out(match), .armed_out(armed), .trace_full_out(full),
		.sequencer_state_out(st));
	dsc_core_model PM (.clock_in(clock_in), .kind_in(kind), .cmp_addr_in(c_addr),
		.cmp_pc_in(c_pc), .cmp_data_in(c_data), .cmp_mask_in(c_mask), .bus_addr_out(b_addr),
		.bus_data_out(b_data), .bus_read_out(b_read), .bus_valid_out(b_valid),
		.pc_out(pc), .pc_valid_out(pc_valid));

	// Free-running 50 MHz clock
	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end

	// Comparison, bus cycles and model helpers
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		if (a == OFS_CMP_CTL && m_arm == 0 && m_prof == 0) m_ctl = d & CMP_CTL_MASK;
		if (a == OFS_CTRL1 && d[BIT_ARM]) begin
			m_st = 1;
			m_full = 0;
		end
		if (a == OFS_CTRL1) m_arm = d[BIT_ARM];
		@(posedge clock_in);
		wr_s <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock_in);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clock_in);
		rd_s <= 1'b0;
		@(negedge clock_in);
		chk(rdata, exp);
	endtask : rd
	task automatic pulse(input int k);
		@(posedge clock_in);
		ev[k] <= 1'b1;
		@(posedge clock_in);
		ev <= 4'h0;
	endtask : pulse
	task automatic hit(input logic [1:0] n);
		@(posedge clock_in);
		nom <= n;
		kind <= 5'h10;
		@(posedge clock_in);
		nom <= 2'b00;
		kind <= 5'h00;
		if (m_arm != 0 && n != 0) m_st = n + 1;
	endtask : hit
	task automatic endt(input string s);
		$display("test %s finished", s);
	endtask : endt
	function automatic logic [7:0] stat();
		return {m_full[0], 2'b00, m_prof[0], 1'b0, m_st[2:0]};
	endfunction : stat
	function automatic logic mexp(input int c, input logic [4:0] k);
		if (c[BIT_PC_SEL]) return c[BIT_CMP_ON] & k[4];
		return c[BIT_CMP_ON] & k[0] & k[2] & (k[3] ^ c[BIT_DATA_MISM])
			& (!c[BIT_DIR_EN] | (k[1] == c[BIT_DIR_VAL]));
	endfunction : mexp
	task automatic final_report;
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report

	// Watchdog cuts a hang short
	initial begin
		#(4000 * 20);
		error_cnt++;
		final_report();
	end

	// Main sequence
	initial begin
		{resetn_in, por_n_in, wr_s, rd_s, addr, wdata, ev, kind, nom} = '0;
		{m_ctl, m_st, m_full, m_prof, m_arm, error_cnt, n_compared} = '0;
		c_addr = 24'($random(seed));
		c_pc = 24'($random(seed));
		c_data = $random(seed);
		c_mask = $random(seed) | 1;
		repeat (5) @(posedge clock_in);
		resetn_in <= 1'b1;
		por_n_in <= 1'b1;
		rd(OFS_STATUS, 8'h00);
		rd(OFS_CMP_CTL, CMP_CTL_RESET);
		rd(8'h7f, 8'h00);
		endt("reset");
		for (i = 0; i < 48; i++) begin
			wr(OFS_CMP_CTL, 8'($random(seed)));
			kind <= 5'($random(seed));
			@(negedge clock_in);
			chk({7'h00, match}, {7'h00, mexp(m_ctl, kind)});
			rd(OFS_CMP_CTL, m_ctl[7:0]);
		end
		kind <= 5'h00;
		endt("comparator");
		wr(OFS_CMP_CTL, 8'h21);
		wr(OFS_CTRL1, 8'h80);
		rd(OFS_STATUS, stat());
		wr(OFS_CMP_CTL, 8'h00);
		rd(OFS_CMP_CTL, m_ctl[7:0]);
		hit(2'b01);
		hit(2'b10);
		rd(OFS_STATUS, stat());
		wr(OFS_CTRL1, 8'h00);
		hit(2'b01);
		rd(OFS_STATUS, stat());
		wr(OFS_CTRL1, 8'h80);
		hit(2'b11);
		@(negedge clock_in);
		chk({5'h00, st}, 8'h04);
		@(negedge clock_in);
		chk({5'h00, st}, 8'h00);
		chk({7'h00, armed}, 8'h00);
		{m_st, m_arm} = '0;
		wr(OFS_CTRL1, 8'h80);
		pulse(3);
		{m_st, m_arm} = '0;
		rd(OFS_STATUS, stat());
		endt("sequencer");
		pulse(0);
		m_full = 1;
		rd(OFS_STATUS, stat());
		@(posedge clock_in);
		resetn_in <= 1'b0;
		@(posedge clock_in);
		resetn_in <= 1'b1;
		m_ctl = 0;
		rd(OFS_STATUS, stat());
		chk({7'h00, full}, 8'h01);
		wr(OFS_CTRL1, 8'h80);
		rd(OFS_STATUS, stat());
		wr(OFS_CTRL1, 8'h00);
		pulse(0);
		@(posedge clock_in);
		por_n_in <= 1'b0;
		@(posedge clock_in);
		por_n_in <= 1'b1;
		rd(OFS_STATUS, 8'h01);
		endt("trace full");
		pulse(1);
		m_prof = 1;
		rd(OFS_STATUS, stat());
		wr(OFS_CMP_CTL, 8'h05);
		rd(OFS_CMP_CTL, m_ctl[7:0]);
		pulse(2);
		m_prof = 0;
		rd(OFS_STATUS, stat());
		wr(OFS_CMP_CTL, 8'h05);
		rd(OFS_CMP_CTL, m_ctl[7:0]);
		endt("profiling");
		final_report();
	end
endmodule : dsc_top_tb
